// ===== core/sbdm_master.sv
// Purpose: system-bus DMA master cycles, ownership and release
// Assumes: bus clock, ack, grant, select and read data arrive on pins
// Notes: bus events follow edges of the synchronised bus clock
`timescale 1ns/1ps
`default_nettype none

module sbdm_master
   import sbdm_pkg::*;
#(
   parameter int FIFO_DEPTH = SBDM_FIFO_DEPTH
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_XFER_VALID,
   input wire logic I_XFER_WRITE,
   input wire logic [SBDM_ADDR_W-1:0] I_XFER_ADDR,
   input wire logic [SBDM_AD_W-1:0] I_XFER_WDATA,
   input wire logic [SBDM_BE_W-1:0] I_XFER_BE,
   output logic O_XFER_TAKEN,
   output logic [SBDM_AD_W-1:0] O_RDATA,
   output logic O_RDATA_VALID,
   input wire logic I_RDATA_READY,
   input wire logic I_SYSTEM_BUS_CLOCK,
   input wire logic [SBDM_AD_W-1:0] I_SYS_ADDR_DATA_LINES,
   output logic [SBDM_AD_W-1:0] O_SYS_ADDR_DATA_LINES,
   output logic O_SYS_ADDR_DATA_LINES_OE,
   output logic O_PARITY_LOW,
   output logic O_PARITY_HIGH,
   output logic O_PARITY_OE,
   output logic O_EXT_ADDR_LATCH_STROBE,
   output logic O_ADDR_LATCH_STROBE,
   output logic O_ADDR_STROBE_N,
   output logic O_UPPER_DATA_STROBE_N,
   output logic O_LOWER_DATA_STROBE_N,
   output logic O_READ_NOT_WRITE,
   output logic O_CTRL_OE,
   output logic O_DATA_BUFFER_ENABLE_N,
   output logic O_DATA_DIRECTION,
   input wire logic I_TRANSFER_ACK_N,
   output logic O_BUS_REQUEST_N,
   input wire logic I_BUS_GRANT_N,
   output logic O_BUS_OWNED_N,
   input wire logic I_SLAVE_CHIP_SELECT_N,
   output logic O_SLAVE_SELECT
);

   // ==========================================================
   // pin synchronisation and bus clock edges
   logic [SBDM_SYNC_W-1:0] pin_level;
   logic bclk_prev;

   sbdm_sync #(
      .WIDTH(SBDM_SYNC_W),
      .RESET_VAL(SBDM_SYNC_RESET)
   ) u_sync (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_raw({I_SYS_ADDR_DATA_LINES, I_SLAVE_CHIP_SELECT_N, I_BUS_GRANT_N,
              I_TRANSFER_ACK_N, I_SYSTEM_BUS_CLOCK}),
      .o_level(pin_level)
   );

   wire bclk = pin_level[SBDM_BIT_CLK];
   wire ack_n = pin_level[SBDM_BIT_ACK];
   wire grant_n = pin_level[SBDM_BIT_GRANT];
   wire cs_n = pin_level[SBDM_BIT_CS];
   wire [SBDM_AD_W-1:0] din = pin_level[SBDM_BIT_DATA +: SBDM_AD_W];
   wire rise_en = bclk & ~bclk_prev;
   wire fall_en = ~bclk & bclk_prev;

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         bclk_prev <= 1'b0;
      end else begin
         bclk_prev <= bclk;
      end
   end

   // ==========================================================
   // transfer state
   sbdm_state_type state;
   sbdm_state_type next_state;
   logic xfer_write;
   logic [SBDM_ADDR_W-1:0] xfer_addr;
   logic [SBDM_AD_W-1:0] xfer_wdata;
   logic [SBDM_BE_W-1:0] xfer_be;
   logic first_xfer;
   logic ack_seen;
   logic rd_push;
   logic [SBDM_AD_W-1:0] rd_data;
   logic fifo_in_ready;

   wire st_idle = (state == SBDM_S_IDLE);
   wire st_ts = (state == SBDM_S_TS);
   wire st_tx = (state == SBDM_S_TX);
   wire st_t1 = (state == SBDM_S_T1);
   wire st_t2 = (state == SBDM_S_T2);
   wire st_wait = (state == SBDM_S_T3) | (state == SBDM_S_TW);
   wire st_t4 = (state == SBDM_S_T4);
   wire st_i1 = (state == SBDM_S_I1);
   wire st_i2 = (state == SBDM_S_I2);

   // a read is taken only while the FIFO can hold its data
   wire req_ok = I_XFER_VALID & (I_XFER_WRITE | fifo_in_ready);
   wire take = rise_en & (st_idle | st_t4) & req_ok;
   wire rd = ~xfer_write;
   wire wr = xfer_write;

   // ==========================================================
   // edge events within states
   wire ev_ts_fall = fall_en & st_ts;
   wire ev_tx_rise = rise_en & st_ts;
   wire ev_tx_fall = fall_en & st_tx;
   wire ev_t1_rise = rise_en & st_tx;
   wire ev_t2_rise = rise_en & st_t1;
   wire ev_t2_fall = fall_en & st_t2;
   wire ev_t3_rise = rise_en & st_t2;
   wire ev_ack_fall = fall_en & st_wait & ~ack_n & ~ack_seen;
   wire ev_t4_rise = rise_en & st_wait & ack_seen;
   wire ev_t4_fall = fall_en & st_t4;
   wire ev_t4_end = rise_en & st_t4;
   wire ev_i1_fall = fall_en & st_i1;
   wire ev_i2_fall = fall_en & st_i2;

   always_comb begin
      next_state = state;
      if (rise_en) begin
         unique case (state)
            SBDM_S_IDLE: if (take) next_state = SBDM_S_ARB;
            SBDM_S_ARB: if (!grant_n) next_state = SBDM_S_TS;
            SBDM_S_TS: next_state = SBDM_S_TX;
            SBDM_S_TX: next_state = SBDM_S_T1;
            SBDM_S_T1: next_state = SBDM_S_T2;
            SBDM_S_T2: next_state = SBDM_S_T3;
            SBDM_S_T3: next_state = ack_seen ? SBDM_S_T4 : SBDM_S_TW;
            SBDM_S_TW: next_state = ack_seen ? SBDM_S_T4 : SBDM_S_TW;
            SBDM_S_T4: next_state = take ? SBDM_S_TS : SBDM_S_I1;
            SBDM_S_I1: next_state = SBDM_S_I2;
            SBDM_S_I2: next_state = SBDM_S_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state <= SBDM_S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         xfer_write <= 1'b0;
         xfer_addr <= '0;
         xfer_wdata <= '0;
         xfer_be <= '0;
         O_XFER_TAKEN <= 1'b0;
      end else begin
         O_XFER_TAKEN <= take;
         if (take) begin
            xfer_write <= I_XFER_WRITE;
            xfer_addr <= I_XFER_ADDR;
            xfer_wdata <= I_XFER_WDATA;
            xfer_be <= I_XFER_BE;
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ack_seen <= 1'b0;
      end else if (ev_ack_fall) begin
         ack_seen <= 1'b1;
      end else if (ev_t4_end) begin
         ack_seen <= 1'b0;
      end
   end

   // ==========================================================
   // read data capture and FIFO
   // capture at falling edge
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rd_push <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_push <= ev_ack_fall & rd;
         if (ev_ack_fall && rd) begin
            rd_data <= din;
         end
      end
   end

   sbdm_fifo #(
      .WIDTH(SBDM_AD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_in_valid(rd_push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(rd_data),
      .o_out_valid(O_RDATA_VALID),
      .i_out_ready(I_RDATA_READY),
      .o_out_data(O_RDATA)
   );

   // ==========================================================
   // arbitration and ownership
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BUS_REQUEST_N <= SBDM_STROBE_OFF;
         first_xfer <= 1'b0;
      end else if (take && st_idle) begin
         O_BUS_REQUEST_N <= ~SBDM_STROBE_OFF;
         first_xfer <= 1'b1;
      end else if (ev_t2_rise && first_xfer) begin
         O_BUS_REQUEST_N <= SBDM_STROBE_OFF;
         first_xfer <= 1'b0;
      end
   end

   // ownership and direction from falling TS to falling I2
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BUS_OWNED_N <= SBDM_STROBE_OFF;
         O_DATA_DIRECTION <= SBDM_DIR_IDLE;
      end else if (ev_ts_fall) begin
         O_BUS_OWNED_N <= ~SBDM_STROBE_OFF;
         O_DATA_DIRECTION <= xfer_write;
      end else if (ev_i2_fall) begin
         O_BUS_OWNED_N <= SBDM_STROBE_OFF;
         O_DATA_DIRECTION <= SBDM_DIR_IDLE;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_SLAVE_SELECT <= 1'b0;
      end else begin
         O_SLAVE_SELECT <= ~cs_n & O_BUS_OWNED_N;
      end
   end

   // ==========================================================
   // address/data lines and parity
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_SYS_ADDR_DATA_LINES <= SBDM_AD_RESET;
         O_SYS_ADDR_DATA_LINES_OE <= 1'b0;
      end else if (ev_ts_fall) begin
         O_SYS_ADDR_DATA_LINES <= xfer_addr[SBDM_ADDR_W-1 -: SBDM_AD_W];
         O_SYS_ADDR_DATA_LINES_OE <= 1'b1;
      end else if (ev_tx_fall) begin
         // low address ahead of address strobe
         O_SYS_ADDR_DATA_LINES <= xfer_addr[SBDM_AD_W-1:0];
      end else if (ev_t2_fall) begin
         // float on reads, drive data on writes
         O_SYS_ADDR_DATA_LINES <= xfer_wdata;
         O_SYS_ADDR_DATA_LINES_OE <= wr;
      end else if (ev_i1_fall) begin
         O_SYS_ADDR_DATA_LINES_OE <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PARITY_LOW <= 1'b0;
         O_PARITY_HIGH <= 1'b0;
         O_PARITY_OE <= 1'b0;
      end else if (ev_t2_fall) begin
         O_PARITY_LOW <= sbdm_odd_parity(xfer_wdata[7:0]);
         O_PARITY_HIGH <= sbdm_odd_parity(xfer_wdata[15:8]);
         O_PARITY_OE <= wr;
      end else if (ev_i1_fall) begin
         O_PARITY_OE <= 1'b0;
      end
   end

   // ==========================================================
   // address latch strobes
   // low from own state until cycle end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_EXT_ADDR_LATCH_STROBE <= SBDM_LATCH_IDLE;
         O_ADDR_LATCH_STROBE <= SBDM_LATCH_IDLE;
      end else begin
         if (ev_tx_rise) begin
            O_EXT_ADDR_LATCH_STROBE <= ~SBDM_LATCH_IDLE;
         end else if (ev_t4_end) begin
            O_EXT_ADDR_LATCH_STROBE <= SBDM_LATCH_IDLE;
         end
         if (ev_t1_rise) begin
            O_ADDR_LATCH_STROBE <= ~SBDM_LATCH_IDLE;
         end else if (ev_t4_end) begin
            O_ADDR_LATCH_STROBE <= SBDM_LATCH_IDLE;
         end
      end
   end

   // ==========================================================
   // address and data strobes
   wire strobe_on_rd = ev_t2_rise & rd;
   wire strobe_on_wr = ev_t3_rise & wr;
   // write strobes end at the acknowledge edge, read strobes at falling T4
   wire strobe_off = (ev_ack_fall & wr) | (ev_t4_fall & rd);

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ADDR_STROBE_N <= SBDM_STROBE_OFF;
      end else if (ev_t1_rise) begin
         O_ADDR_STROBE_N <= ~SBDM_STROBE_OFF;
      end else if (strobe_off) begin
         O_ADDR_STROBE_N <= SBDM_STROBE_OFF;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_UPPER_DATA_STROBE_N <= SBDM_STROBE_OFF;
         O_LOWER_DATA_STROBE_N <= SBDM_STROBE_OFF;
      end else if (strobe_on_rd || strobe_on_wr) begin
         O_UPPER_DATA_STROBE_N <= ~xfer_be[1];
         O_LOWER_DATA_STROBE_N <= ~xfer_be[0];
      end else if (strobe_off) begin
         O_UPPER_DATA_STROBE_N <= SBDM_STROBE_OFF;
         O_LOWER_DATA_STROBE_N <= SBDM_STROBE_OFF;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_CTRL_OE <= 1'b0;
         O_READ_NOT_WRITE <= 1'b1;
      end else if (ev_ts_fall) begin
         O_CTRL_OE <= 1'b1;
         O_READ_NOT_WRITE <= rd;
      end else if (ev_i1_fall) begin
         O_CTRL_OE <= 1'b0;
      end
   end

   // ==========================================================
   // data buffer enable
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DATA_BUFFER_ENABLE_N <= SBDM_STROBE_OFF;
      end else if ((ev_t1_rise && wr) || (ev_t2_rise && rd)) begin
         // write at T1, read at T2
         O_DATA_BUFFER_ENABLE_N <= ~SBDM_STROBE_OFF;
      end else if ((ev_t4_rise && wr) || (ev_t4_fall && rd)) begin
         // write after strobes, read at falling T4
         O_DATA_BUFFER_ENABLE_N <= SBDM_STROBE_OFF;
      end
   end

endmodule // sbdm_master
`default_nettype wire

// ===== core/sbdm_pkg.sv
// Purpose: constants, state type and helpers of the DMA master
// Assumes: 16-bit multiplexed address/data bus, 32-bit DMA address
// Notes: pin levels here are those driven while the bus is idle
package sbdm_pkg;

   // ==========================================================
   // widths and sizes
   localparam int SBDM_AD_W = 16;
   localparam int SBDM_ADDR_W = 32;
   localparam int SBDM_BE_W = 2;
   localparam int SBDM_FIFO_DEPTH = 4;

   // ==========================================================
   // layout of the synchronised pin inputs
   localparam int SBDM_SYNC_W = 20;
   localparam int SBDM_BIT_CLK = 0;
   localparam int SBDM_BIT_ACK = 1;
   localparam int SBDM_BIT_GRANT = 2;
   localparam int SBDM_BIT_CS = 3;
   localparam int SBDM_BIT_DATA = 4;
   localparam logic [SBDM_SYNC_W-1:0] SBDM_SYNC_RESET = 20'h0000e;

   // ==========================================================
   // idle levels of driven pins
   localparam logic SBDM_STROBE_OFF = 1'b1;
   localparam logic SBDM_LATCH_IDLE = 1'b1;
   localparam logic SBDM_DIR_IDLE = 1'b1;
   localparam logic [SBDM_AD_W-1:0] SBDM_AD_RESET = 16'h0000;

   // ==========================================================
   // bus states
   typedef enum logic [3:0] {
      SBDM_S_IDLE,
      SBDM_S_ARB,
      SBDM_S_TS,
      SBDM_S_TX,
      SBDM_S_T1,
      SBDM_S_T2,
      SBDM_S_T3,
      SBDM_S_TW,
      SBDM_S_T4,
      SBDM_S_I1,
      SBDM_S_I2
   } sbdm_state_type;

   // odd parity over one byte
   function automatic logic sbdm_odd_parity(input logic [7:0] b);
      return ~(^b);
   endfunction

endpackage

// ===== core/sbdm_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to i_clk
// Notes: a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sbdm_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_raw,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire [WIDTH-1:0] next_level = (stage2 & stage3) | (o_level & (stage2 ^ stage3));

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
         o_level <= RESET_VAL;
      end else begin
         stage1 <= i_raw;
         stage2 <= stage1;
         stage3 <= stage2;
         o_level <= next_level;
      end
   end

endmodule // sbdm_sync
`default_nettype wire

// ===== core/sbdm_fifo.sv
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module sbdm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;

   wire do_push = i_in_valid & o_in_ready;
   wire do_pop = o_out_valid & i_out_ready;

   assign o_in_ready = (count != FULL_COUNT);
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];

   always_ff @(posedge i_clk) begin
      if (do_push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + PTR_W'(1);
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + PTR_W'(1);
         end
         if (do_push && !do_pop) begin
            count <= count + CNT_W'(1);
         end else if (do_pop && !do_push) begin
            count <= count - CNT_W'(1);
         end
      end
   end

endmodule // sbdm_fifo
`default_nettype wire

// ===== bench/sbdm_master_checker.sv
// Purpose: concurrent checks on sbdm_master ports
// Assumes: slave holds ack until address strobe ends
// Notes: bound into sbdm_master
`timescale 1ns/1ps
`default_nettype none
module sbdm_master_checker
   import sbdm_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_TRANSFER_ACK_N,
   input wire logic [SBDM_AD_W-1:0] O_SYS_ADDR_DATA_LINES,
   input wire logic O_SYS_ADDR_DATA_LINES_OE,
   input wire logic O_PARITY_LOW,
   input wire logic O_PARITY_HIGH,
   input wire logic O_PARITY_OE,
   input wire logic O_EXT_ADDR_LATCH_STROBE,
   input wire logic O_ADDR_LATCH_STROBE,
   input wire logic O_ADDR_STROBE_N,
   input wire logic O_UPPER_DATA_STROBE_N,
   input wire logic O_LOWER_DATA_STROBE_N,
   input wire logic O_READ_NOT_WRITE,
   input wire logic O_CTRL_OE,
   input wire logic O_DATA_BUFFER_ENABLE_N,
   input wire logic O_DATA_DIRECTION,
   input wire logic O_BUS_REQUEST_N,
   input wire logic O_BUS_OWNED_N,
   input wire logic O_SLAVE_SELECT
);
   // half bus period plus margin
   localparam int FLOAT_MAX = 10;
   wire rnw = O_READ_NOT_WRITE;
   wire as_n = O_ADDR_STROBE_N;
   wire uds_n = O_UPPER_DATA_STROBE_N;
   wire lds_n = O_LOWER_DATA_STROBE_N;
   wire dben_n = O_DATA_BUFFER_ENABLE_N;
   wire own_n = O_BUS_OWNED_N;
   wire ad_oe = O_SYS_ADDR_DATA_LINES_OE;
   wire wr_ds = !rnw && !(uds_n && lds_n);
   wire [SBDM_AD_W-1:0] ad = O_SYS_ADDR_DATA_LINES;

   // ==========================================================
   // bus cycle checks
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   a_as_after_addr: assert property (
      $fell(as_n) |-> $fell(O_ADDR_LATCH_STROBE) && !O_EXT_ADDR_LATCH_STROBE && ad_oe)
      else $error("strobe before address");
   a_latch_hold: assert property (
      (!as_n || !uds_n) |-> !O_EXT_ADDR_LATCH_STROBE && !O_ADDR_LATCH_STROBE)
      else $error("latch high in cycle");
   a_rd_strobes: assert property (
      $fell(dben_n) && rnw |-> ($fell(uds_n) || $fell(lds_n)) && !as_n)
      else $error("read enable apart");
   a_rd_float: assert property (
      $fell(dben_n) && rnw |-> ad_oe ##[1:FLOAT_MAX] !ad_oe)
      else $error("no read float");
   a_wr_dben_t1: assert property (
      $fell(dben_n) && !rnw |-> $fell(as_n))
      else $error("write enable late");
   a_rd_end: assert property (
      $rose(as_n) && rnw |-> $rose(dben_n) && uds_n && lds_n)
      else $error("read end split");
   a_wr_dben_hold: assert property (
      $rose(uds_n) && !rnw |-> !dben_n [*3])
      else $error("write enable early off");
   a_wr_data: assert property (
      wr_ds |-> $stable(ad) && ad_oe && O_PARITY_OE && O_PARITY_LOW == ~^ad[7:0]
         && O_PARITY_HIGH == ~^ad[15:8])
      else $error("write data wrong");
   a_ack_before_end: assert property (
      $rose(as_n) |-> !I_TRANSFER_ACK_N)
      else $error("end without ack");
   a_release_float: assert property (
      $rose(own_n) |-> !O_CTRL_OE && !ad_oe && !O_PARITY_OE && O_DATA_DIRECTION
         && !$past(O_CTRL_OE, 4))
      else $error("release early");
   a_cs_ignored: assert property (
      !own_n && !$past(own_n) |-> !O_SLAVE_SELECT)
      else $error("select while owned");
   a_req_at_t2: assert property (
      $rose(O_BUS_REQUEST_N) |-> !own_n && !dben_n && !$past(as_n))
      else $error("request drop misplaced");

   c_read_end: cover property ($rose(as_n) && rnw);
   c_write_end: cover property ($rose(as_n) && !rnw);
   c_release: cover property ($rose(own_n));
endmodule // sbdm_master_checker

bind sbdm_master sbdm_master_checker u_chk (.*);
`default_nettype wire

// ===== bench/sbdm_slave_model.sv
// Purpose: system-bus slave memory and bus grant
// Assumes: address halves stand at latch strobe falls
// Notes: i_wait is the ack latency in clock cycles
`timescale 1ns/1ps
`default_nettype none
module sbdm_slave_model
   import sbdm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_wait,
   input wire logic [SBDM_AD_W-1:0] i_ad,
   input wire logic i_ad_oe,
   input wire logic i_par_lo,
   input wire logic i_par_hi,
   input wire logic i_xal,
   input wire logic i_ale,
   input wire logic i_as_n,
   input wire logic i_uds_n,
   input wire logic i_lds_n,
   input wire logic i_rnw,
   input wire logic i_dben_n,
   input wire logic i_req_n,
   output logic [SBDM_AD_W-1:0] o_ad,
   output logic o_ack_n,
   output logic o_grant_n
);
   logic [SBDM_AD_W-1:0] mem [16];
   logic [1:0] par [16];
   logic [SBDM_AD_W-1:0] addr_hi, addr_lo, last;
   logic xal_d, ale_d;
   logic [7:0] cnt;
   wire ds_on = !i_uds_n || !i_lds_n;
   // ==========================================================
   // released lines show a changing pattern
   // read data only under strobe and buffer enable
   wire rd_drive = i_rnw && ds_on && !i_dben_n && !i_ad_oe && !i_as_n;
   assign o_ad = i_ad_oe ? i_ad : (rd_drive ? mem[addr_lo[3:0]] : ~last);

   // ==========================================================
   // address, acknowledge and memory
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 16; i++) begin
            mem[i] <= {12'h3c5, i[3:0]};
            par[i] <= 2'h0;
         end
         {addr_hi, addr_lo, last, cnt} <= '0;
         {xal_d, ale_d, o_ack_n, o_grant_n} <= 4'hf;
      end else begin
         last <= o_ad;
         xal_d <= i_xal;
         ale_d <= i_ale;
         o_grant_n <= i_req_n;
         if (xal_d && !i_xal) addr_hi <= i_ad;
         if (ale_d && !i_ale) addr_lo <= i_ad;
         // ack after valid data, held until strobe ends
         if (i_as_n) begin
            o_ack_n <= 1'b1;
            cnt <= 8'h00;
         end else if (o_ack_n && (rd_drive || (!i_rnw && ds_on))) begin
            if (cnt == i_wait) begin
               o_ack_n <= 1'b0;
               if (!i_rnw && !i_uds_n) mem[addr_lo[3:0]][15:8] <= i_ad[15:8];
               if (!i_rnw && !i_lds_n) mem[addr_lo[3:0]][7:0] <= i_ad[7:0];
               if (!i_rnw) par[addr_lo[3:0]] <= {i_par_hi, i_par_lo};
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule // sbdm_slave_model
`default_nettype wire

// ===== bench/sbdm_master_tb_top.sv
// Purpose: self-checking bench for sbdm_master
// Assumes: bus clock half period of 6 clock cycles
// Notes: chip select stays low so it is ignored while owned
`timescale 1ns/1ps
`default_nettype none
module sbdm_master_tb_top
   import sbdm_pkg::*;
;
   logic I_CLK, I_RST_N, I_XFER_VALID, I_XFER_WRITE, I_RDATA_READY, I_SYSTEM_BUS_CLOCK;
   logic I_TRANSFER_ACK_N, I_BUS_GRANT_N, I_SLAVE_CHIP_SELECT_N, O_XFER_TAKEN, O_RDATA_VALID;
   logic [SBDM_ADDR_W-1:0] I_XFER_ADDR;
   logic [SBDM_AD_W-1:0] I_XFER_WDATA, O_RDATA, I_SYS_ADDR_DATA_LINES, O_SYS_ADDR_DATA_LINES;
   logic [SBDM_BE_W-1:0] I_XFER_BE;
   logic O_SYS_ADDR_DATA_LINES_OE, O_PARITY_LOW, O_PARITY_HIGH, O_PARITY_OE, O_CTRL_OE;
   logic O_EXT_ADDR_LATCH_STROBE, O_ADDR_LATCH_STROBE, O_ADDR_STROBE_N, O_READ_NOT_WRITE;
   logic O_UPPER_DATA_STROBE_N, O_LOWER_DATA_STROBE_N, O_DATA_BUFFER_ENABLE_N, O_DATA_DIRECTION;
   logic O_BUS_REQUEST_N, O_BUS_OWNED_N, O_SLAVE_SELECT;
   logic [7:0] wait_cyc;
   int bad_count, tests_run, cycles, bdiv;

   sbdm_master u_dut (.*);
   sbdm_slave_model u_slv (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_wait(wait_cyc),
      .i_ad(O_SYS_ADDR_DATA_LINES), .i_ad_oe(O_SYS_ADDR_DATA_LINES_OE),
      .i_par_lo(O_PARITY_LOW), .i_par_hi(O_PARITY_HIGH), .i_xal(O_EXT_ADDR_LATCH_STROBE),
      .i_ale(O_ADDR_LATCH_STROBE), .i_as_n(O_ADDR_STROBE_N), .i_uds_n(O_UPPER_DATA_STROBE_N),
      .i_lds_n(O_LOWER_DATA_STROBE_N), .i_rnw(O_READ_NOT_WRITE), .i_dben_n(O_DATA_BUFFER_ENABLE_N),
      .i_req_n(O_BUS_REQUEST_N), .o_ad(I_SYS_ADDR_DATA_LINES), .o_ack_n(I_TRANSFER_ACK_N),
      .o_grant_n(I_BUS_GRANT_N));

   // ==========================================================
   // clocks and run limit
   always #12.5 I_CLK = ~I_CLK;
   always @(posedge I_CLK) begin
      bdiv <= (bdiv == 5) ? 0 : bdiv + 1;
      if (bdiv == 5) I_SYSTEM_BUS_CLOCK <= ~I_SYSTEM_BUS_CLOCK;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         stop_test();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic check(input logic [SBDM_AD_W-1:0] seen, input logic [SBDM_AD_W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic req(input logic w, input logic [SBDM_ADDR_W-1:0] a,
                      input logic [SBDM_AD_W-1:0] d, input logic [SBDM_BE_W-1:0] be);
      @(posedge I_CLK);
      I_XFER_VALID <= 1'b1;
      I_XFER_WRITE <= w;
      I_XFER_ADDR <= a;
      I_XFER_WDATA <= d;
      I_XFER_BE <= be;
   endtask
   // waits for the take pulse, then drops the request
   task automatic taken(input int lim, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge I_CLK);
         if (O_XFER_TAKEN === 1'b1) begin
            ok = 1'b1;
            I_XFER_VALID <= 1'b0;
         end
      end
   endtask
   task automatic xfer(input logic w, input logic [SBDM_ADDR_W-1:0] a,
                       input logic [SBDM_AD_W-1:0] d, input logic [SBDM_BE_W-1:0] be);
      bit ok;
      req(w, a, d, be);
      taken(800, ok);
      check({15'h0, ok}, 16'h0001);
   endtask
   task automatic wait_idle();
      bit own = 1'b0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge I_CLK);
         if (O_BUS_OWNED_N === 1'b0) own = 1'b1;
         else if (own) break;
      end
   endtask
   task automatic pop_check(input logic [SBDM_AD_W-1:0] exp);
      int i = 0;
      @(posedge I_CLK);
      while (O_RDATA_VALID !== 1'b1 && i < 800) begin
         @(posedge I_CLK);
         i++;
      end
      check(O_RDATA, exp);
      I_RDATA_READY <= 1'b1;
      @(posedge I_CLK);
      I_RDATA_READY <= 1'b0;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      check({11'h0, O_BUS_OWNED_N, O_DATA_DIRECTION, O_BUS_REQUEST_N, O_CTRL_OE,
             O_SYS_ADDR_DATA_LINES_OE}, 16'h001c);
      I_SLAVE_CHIP_SELECT_N <= 1'b0;
      repeat (8) @(posedge I_CLK);
      check({15'h0, O_SLAVE_SELECT}, 16'h0001);
      $display("test reset done");
   endtask
   task automatic t_write();
      xfer(1'b1, 32'h00a1_0003, 16'h5a3c, 2'b11);
      xfer(1'b1, 32'h00a1_0004, 16'h81ff, 2'b10);
      wait_idle();
      check(u_slv.mem[3], 16'h5a3c);
      check(u_slv.mem[4], 16'h8154);
      check({14'h0, u_slv.par[3]}, {14'h0, ~^8'h5a, ~^8'h3c});
      check(u_slv.addr_hi, 16'h00a1);
      $display("test write done");
   endtask
   task automatic t_read();
      wait_cyc <= 8'd20;
      xfer(1'b0, 32'h00a1_0003, 16'h0000, 2'b11);
      xfer(1'b0, 32'h00a1_0004, 16'h0000, 2'b01);
      pop_check(16'h5a3c);
      pop_check(16'h8154);
      wait_idle();
      $display("test read done");
   endtask
   task automatic t_fill();
      bit ok;
      wait_cyc <= 8'd3;
      for (int k = 8; k < 12; k++) xfer(1'b0, {28'h00a1000, k[3:0]}, 16'h0000, 2'b11);
      req(1'b0, 32'h00a1_000c, 16'h0000, 2'b11);
      taken(600, ok);
      check({15'h0, ok}, 16'h0000);
      pop_check(16'h3c58);
      taken(800, ok);
      check({15'h0, ok}, 16'h0001);
      for (int k = 9; k < 12; k++) pop_check({12'h3c5, k[3:0]});
      wait_idle();
      pop_check(16'h3c5c);
      @(posedge I_CLK);
      check({15'h0, O_RDATA_VALID}, 16'h0000);
      $display("test fill done");
   endtask

   task automatic stop_test();
      $display("run %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      {I_CLK, I_RST_N, I_XFER_VALID, I_XFER_WRITE, I_RDATA_READY, I_SYSTEM_BUS_CLOCK} = '0;
      {I_XFER_ADDR, I_XFER_WDATA, I_XFER_BE, wait_cyc} = '0;
      I_SLAVE_CHIP_SELECT_N = 1'b1;
      {bad_count, tests_run, cycles, bdiv} = '0;
      repeat (6) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_fill();
      stop_test();
   end
endmodule // sbdm_master_tb_top
`default_nettype wire
